// [verilog/sadc_regs.svh]
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// Conversion clock is clk_i itself, 125 MHz
`define SADC_CLK_PERIOD_PS 8000
// Sampling phase length in clock periods
`define SADC_SAMPLE_CYCLES 6'd32
// Abort window: a start inside this many periods restarts the conversion
`define SADC_ABORT_CYCLES 7'd64
// Clock periods spent on each bit trial
`define SADC_TRIAL_CYCLES 3'd4
// Number of result bits
`define SADC_NUM_BITS 4'd8
// Whole conversion bounds in clock periods
`define SADC_CONV_MIN_CYCLES 57
`define SADC_CONV_MAX_CYCLES 74
// Done delay: 8 clock periods plus this time in ns
`define SADC_DONE_EXTRA_NS 2000
`define SADC_DONE_EXTRA_CYCLES ((`SADC_DONE_EXTRA_NS * 1000) / `SADC_CLK_PERIOD_PS)
`define SADC_DONE_MAX_CYCLES (8 + `SADC_DONE_EXTRA_CYCLES)
// Trial weight of the first bit
`define SADC_MSB_WEIGHT 8'h80
// Result codes at the two ends of the input range
`define SADC_CODE_ZERO 8'h00
`define SADC_CODE_FULL 8'hff

`endif

// [verilog/sadc_pkg.sv]
package sadc_pkg;

    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_SAMPLE,
        SADC_TRIAL,
        SADC_LATCH
    } sadc_state_t;

    // Comparator request to the analog side and the chosen input
    typedef struct packed {
        logic [7:0] trial_code;
        logic [7:0] channel_sel;
        logic sample_en;
        logic trial_en;
    } sadc_analog_t;

endpackage

// [verilog/sadc_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module sadc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,              // Clock
    input wire logic rst_n_i,            // Async reset, active low
    input wire logic [WIDTH-1:0] d_i,    // Asynchronous inputs
    output logic [WIDTH-1:0] q_o         // Synchronised inputs
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

`default_nettype wire

// [verilog/sadc_chan_dec.sv]
`timescale 1ns/10ps
`default_nettype none

module sadc_chan_dec (
    input wire logic clk_i,              // Clock
    input wire logic rst_n_i,            // Async reset, active low
    input wire logic [2:0] addr_i,       // Synchronised address, bit 2 is input C
    input wire logic load_rise_i,        // One-cycle pulse on strobe rising edge
    output logic [2:0] addr_o,           // Latched address
    output logic [7:0] sel_o             // One-hot channel select
);

    logic [2:0] addr_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= 3'h0;
        end else if (load_rise_i) begin
            addr_q <= addr_i;
        end
    end

    // Channel number is the plain binary value of C,B,A
    genvar g;
    for (g = 0; g < 8; g++) begin : g_sel
        assign sel_o[g] = (addr_q == 3'(g));
    end

    assign addr_o = addr_q;

    chk_one_hot_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $onehot(sel_o) && sel_o[addr_q]) else $error("channel select not one-hot");
    chk_addr_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !load_rise_i |=> $stable(addr_q)) else $error("address moved without strobe");
    chk_addr_loads: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        load_rise_i |=> addr_q == $past(addr_i)) else $error("address not loaded");

endmodule

`default_nettype wire

// [verilog/sadc_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sadc_regs.svh"

// Overview of operation
// - Three address bits choose exactly one of eight analog inputs.
// - Address is latched on strobe rising edge and held until the next.
// - Start rising edge clears the result latch.
// - Start rising edge begins 32 periods of sampling before the trials.
// - A start within 64 periods aborts and restarts, dropping partial data.
// - Done output fed back to start gives free-running conversion.
// - Bits resolve one per trial, weight 128 first, down to the LSB.
// - Each comparator decision becomes that bit and keeps or drops the weight.
// - After eight bits conversion ends; the next repeats sample then convert.
// - Done changes within 8 periods plus 2 us of the start pulse.
// - Result sits in a latch whose outputs drive only when enabled.
// - Result is straight binary, zeros at zero input, ones at full scale.
// - A whole conversion takes 57 to 74 clock periods.
module sadc_ctrl (
    input wire logic clk_i,                  // Conversion clock, 125 MHz
    input wire logic rst_n_i,                // Async reset, active low
    input wire logic [2:0] addr_i,           // Channel address pins, bit 2 is C
    input wire logic addr_load_i,            // Address load strobe pin
    input wire logic start_i,                // Start of conversion pin
    input wire logic result_drive_enable_i,  // Output enable pin, high drives data
    input wire logic cmp_above_i,            // Comparator: input above trial level
    output sadc_pkg::sadc_analog_t analog_o, // Requests to the analog side
    output logic conv_done_o,                // End of conversion, high when done
    output logic [7:0] result_o,             // Result data out
    output logic [7:0] result_oe_o           // Result drive enable per bit
);

    logic [2:0] addr_s;
    logic load_s;
    logic start_s;
    logic cmp_s;
    logic load_prev_q;
    logic start_prev_q;
    logic load_rise;
    logic start_rise;
    logic [7:0] chan_sel;
    logic [2:0] chan_addr;

    logic en_s;
    logic [6:0] sync_out;
    sadc_pkg::sadc_state_t state_q;
    logic [5:0] sample_cnt_q;
    logic [2:0] phase_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] weight_q;
    logic [7:0] trial_code_q;
    logic [7:0] decided;
    logic [7:0] result_q;
    logic [7:0] oe_q;
    logic [7:0] chan_sel_q;
    logic [6:0] conv_age_q;
    logic done_q;
    logic sample_end;
    logic phase_end;
    logic last_bit;

    // Every pin, the comparator included, crosses in through two flops
    sadc_sync #(
        .WIDTH(7)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({addr_i, addr_load_i, start_i, cmp_above_i, result_drive_enable_i}),
        .q_o(sync_out)
    );

    assign addr_s = sync_out[6:4];
    assign load_s = sync_out[3];
    assign start_s = sync_out[2];
    assign cmp_s = sync_out[1];
    assign en_s = sync_out[0];

    // Edge detectors reset to the idle low level of their pins, so no false edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_prev_q <= 1'b0;
        end else begin
            load_prev_q <= load_s;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= start_s;
        end
    end

    assign load_rise = load_s & ~load_prev_q;
    assign start_rise = start_s & ~start_prev_q;

    sadc_chan_dec u_chan_dec (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr_s),
        .load_rise_i(load_rise),
        .addr_o(chan_addr),
        .sel_o(chan_sel)
    );

    // Select goes out of a flop so the analog switches never see decode glitches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chan_sel_q <= 8'h01;
        end else begin
            chan_sel_q <= chan_sel;
        end
    end

    assign sample_end = (state_q == sadc_pkg::SADC_SAMPLE) &&
        (sample_cnt_q == `SADC_SAMPLE_CYCLES - 6'd1);
    assign phase_end = (state_q == sadc_pkg::SADC_TRIAL) &&
        (phase_q == `SADC_TRIAL_CYCLES - 3'd1);
    assign last_bit = (bit_cnt_q == `SADC_NUM_BITS - 4'd1);

    // Any start edge restarts; a late one past the abort window does the same
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= sadc_pkg::SADC_IDLE;
        end else if (start_rise) begin
            state_q <= sadc_pkg::SADC_SAMPLE;
        end else begin
            case (state_q)
                sadc_pkg::SADC_IDLE: begin
                    state_q <= sadc_pkg::SADC_IDLE;
                end
                sadc_pkg::SADC_SAMPLE: begin
                    if (sample_end) begin
                        state_q <= sadc_pkg::SADC_TRIAL;
                    end
                end
                sadc_pkg::SADC_TRIAL: begin
                    if (phase_end && last_bit) begin
                        state_q <= sadc_pkg::SADC_LATCH;
                    end
                end
                sadc_pkg::SADC_LATCH: begin
                    state_q <= sadc_pkg::SADC_IDLE;
                end
                default: begin
                    state_q <= sadc_pkg::SADC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_cnt_q <= 6'h00;
        end else if (start_rise) begin
            sample_cnt_q <= 6'h00;
        end else if (state_q == sadc_pkg::SADC_SAMPLE) begin
            sample_cnt_q <= sample_cnt_q + 6'd1;
        end
    end

    // Four periods per trial leave room for the two-flop comparator path
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 3'h0;
        end else if (start_rise || (state_q != sadc_pkg::SADC_TRIAL)) begin
            phase_q <= 3'h0;
        end else if (phase_end) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'd1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_q <= 4'h0;
        end else if (start_rise || (state_q != sadc_pkg::SADC_TRIAL)) begin
            bit_cnt_q <= 4'h0;
        end else if (phase_end) begin
            bit_cnt_q <= bit_cnt_q + 4'd1;
        end
    end

    // The bit under trial takes the decision, the others keep what they hold
    genvar b;
    for (b = 0; b < 8; b++) begin : g_bit
        assign decided[b] = weight_q[b] ? cmp_s : trial_code_q[b];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            weight_q <= 8'h00;
            trial_code_q <= 8'h00;
        end else if (start_rise) begin
            // A restart drops whatever part of the result was built
            weight_q <= 8'h00;
            trial_code_q <= 8'h00;
        end else if (sample_end) begin
            weight_q <= `SADC_MSB_WEIGHT;
            trial_code_q <= `SADC_MSB_WEIGHT;
        end else if (phase_end) begin
            weight_q <= weight_q >> 1;
            trial_code_q <= decided | (weight_q >> 1);
        end
    end

    // Restart wins over the latch step, so a cut conversion never lands
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_q <= `SADC_CODE_ZERO;
        end else if (start_rise) begin
            result_q <= `SADC_CODE_ZERO;
        end else if (state_q == sadc_pkg::SADC_LATCH) begin
            result_q <= trial_code_q;
        end
    end

    // Done low after reset: a free-running loop needs one outside start pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
        end else if (start_rise) begin
            done_q <= 1'b0;
        end else if (state_q == sadc_pkg::SADC_LATCH) begin
            done_q <= 1'b1;
        end
    end

    // Periods since the last start edge, saturating
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_age_q <= 7'h00;
        end else if (start_rise) begin
            conv_age_q <= 7'h00;
        end else if (conv_age_q != 7'h7f) begin
            conv_age_q <= conv_age_q + 7'd1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_q <= 8'h00;
        end else begin
            oe_q <= {8{en_s}};
        end
    end

    always_comb begin
        analog_o = '0;
        analog_o.trial_code = trial_code_q;
        analog_o.channel_sel = chan_sel_q;
        analog_o.sample_en = (state_q == sadc_pkg::SADC_SAMPLE);
        analog_o.trial_en = (state_q == sadc_pkg::SADC_TRIAL);
    end

    assign conv_done_o = done_q;
    assign result_o = result_q;
    assign result_oe_o = oe_q;

    sequence s_start_edge;
        start_rise;
    endsequence

    sequence s_sampling;
        (state_q == sadc_pkg::SADC_SAMPLE) [*8];
    endsequence

    sequence s_first_trial;
        (state_q == sadc_pkg::SADC_TRIAL) && (trial_code_q == `SADC_MSB_WEIGHT);
    endsequence

    chk_start_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_start_edge |=> (result_q == `SADC_CODE_ZERO)) else $error("result not cleared");
    chk_sample_phase: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_start_edge |=> s_sampling) else $error("sampling phase cut short");
    chk_msb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sample_end && !start_rise) |=> s_first_trial) else $error("first trial not MSB");
    chk_abort_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (start_rise && (conv_age_q < `SADC_ABORT_CYCLES) && (state_q != sadc_pkg::SADC_IDLE))
        |=> (state_q == sadc_pkg::SADC_SAMPLE) && (sample_cnt_q == 6'h00) &&
        (trial_code_q == 8'h00)) else $error("restart did not discard");
    chk_done_falls: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_start_edge |-> ##[1:8] !conv_done_o) else $error("done did not fall");
    chk_conv_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(conv_done_o) |-> (conv_age_q >= `SADC_CONV_MIN_CYCLES) &&
        (conv_age_q <= `SADC_CONV_MAX_CYCLES)) else $error("conversion length off");
    chk_chan_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        chan_sel_q == (8'h01 << $past(chan_addr))) else $error("channel select stale");

endmodule

`default_nettype wire

// [test/sadc_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

module sadc_host_model (
    input wire logic [7:0] level_i, // Analog level as a code
    input wire logic [7:0] trial_i, // Trial code
    input wire logic req_i,         // Host start pulse
    input wire logic loop_i,        // Free-run mode
    input wire logic done_i,        // Conversion done
    output logic start_o,           // Start pin
    output logic above_o            // Comparator decision
);
    assign above_o = level_i >= trial_i;
    // Host pulse still needed once so the loop can begin
    assign start_o = req_i | (loop_i & done_i);
endmodule

`default_nettype wire

// [test/eight_channel_sar_adc_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module eight_channel_sar_adc_control_tb;
    logic clk_i = 1'b0, rst_n_i = 1'b0, addr_load_i = 1'b0, req = 1'b0, loop = 1'b0;
    logic result_drive_enable_i = 1'b0, start_i, cmp_above_i, conv_done_o;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] lvl = 8'h00, result_o, result_oe_o;
    sadc_pkg::sadc_analog_t analog_o;
    int fail_count = 0, n_checks = 0, cyc = 0;
    always #4 clk_i = ~clk_i;
    sadc_ctrl u_dut (.clk_i, .rst_n_i, .addr_i, .addr_load_i, .start_i, .result_drive_enable_i,
        .cmp_above_i, .analog_o, .conv_done_o, .result_o, .result_oe_o);
    sadc_host_model u_host (.level_i(lvl), .trial_i(analog_o.trial_code), .req_i(req),
        .loop_i(loop), .done_i(conv_done_o), .start_o(start_i), .above_o(cmp_above_i));
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic channels;
        for (int a = 0; a < 8; a++) begin
            addr_i = 3'(a);
            addr_load_i = 1'b1;
            repeat (25) @(negedge clk_i);
            addr_load_i = 1'b0;
            repeat (7) @(negedge clk_i);
            addr_i = ~3'(a);
            repeat (4) @(negedge clk_i);
            chk("channel", analog_o.channel_sel, 8'h01 << a);
        end
        $display("channel test done");
    endtask
    // Early restart leaves a half-done conversion behind to be discarded
    task automatic convert(input logic [7:0] v, input int early);
        int n = 0;
        bit low = 0;
        lvl = v;
        result_drive_enable_i = 1'b1;
        req = 1'b1;
        if (early > 0) begin
            repeat (25) @(negedge clk_i);
            req = 1'b0;
            repeat (early) @(negedge clk_i);
            req = 1'b1;
        end
        while (!(low && conv_done_o === 1'b1) && n < 300) begin
            @(negedge clk_i);
            n++;
            if (n == 25) req = 1'b0;
            if (n == 10) chk("cleared", result_o, 8'h00);
            low |= conv_done_o === 1'b0;
        end
        chk("in time", 8'(n >= 57 && n <= 74), 8'h01);
        chk("result", result_o, v);
        chk("drive", result_oe_o, 8'hff);
        result_drive_enable_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("released", result_oe_o, 8'h00);
        $display("conversion %h done", v);
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        channels();
        convert(8'h00, 0);
        convert(8'hff, 0);
        convert(8'ha5, 0);
        convert(8'h5a, 20);
        loop = 1'b1;
        convert(8'hc3, 0);
        repeat (40) @(negedge clk_i);
        chk("free run", {7'h0, conv_done_o}, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
